// [rtl/acpi_sleep_rail_sequencer.sv]
// Purpose: Control logic of a triple power-rail sleep sequencer.
// Assumes: Pins are asynchronous; analog comparators arrive as levels.
// Notes:   Registers reached over AHB-Lite, zero wait states.
// Operation
// - Capture both enables on sleep entry, reset release, shutdown exit.
// - Enable changes during sleep states are ignored.
// - Latch memory voltage selection 3ms after reset release, keep it.
// - Drive fault pin high on under-voltage or over-temperature.
// - Soft-start pulled low turns all drives off, fault forced low.
// - Hold internal reset until standby supply is good for 3.3ms.
// - Start soft-start into suspend or soft-off once the selection is latched after reset release.
// - 3.3V dual on in active and suspend; soft-off on when enable 0.
// - 5V dual on in active; in sleep only when its enable is 1.
// - Memory rail on in active and suspend, off in soft-off.
// - Invalid request combination keeps previous valid state.
// - Only active-to-sleep and sleep-to-active moves are accepted.
// - Request change starts 200us timer; adopt only valid request then.
// - Memory drive regulates for 2.5V, fully on for 3.3V.
// - Active switch drive on in active states, off in sleep.
// - Standby 5V drive on in sleep when 5V dual is enabled.
// - Standby 3.3V drive on in suspend, in soft-off only when enable 0, off in active.
// - Memory, 3.3V dual and 5V dual rails monitored for under-voltage.
// - Both requests high at power-up: drives off until 50ms past 12V.
// - Sleep request during active ramp: full reset, new soft-start.
`timescale 1ns/1ps
`include "sleep_seq_defines.svh"

module acpi_sleep_rail_sequencer
#(
	parameter int POR_EXT_CYC      = `POR_EXT_CYC,
	parameter int MSEL_LATCH_CYC   = `MSEL_LATCH_CYC,
	parameter int DEGLITCH_CYC     = `DEGLITCH_CYC,
	parameter int MAIN12V_WAIT_CYC = `MAIN12V_WAIT_CYC
)
(
	// Clock and reset.
	input  wire logic        CLK,
	input  wire logic        NRST,
	// AHB-Lite slave.
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic             HREADYOUT,
	output logic             HRESP,
	output logic [31:0]      HRDATA,
	// Sleep requests and enables from the chipset.
	input  wire logic        SUSPEND_RAM_REQ_N,
	input  wire logic        SOFT_OFF_REQ_N,
	input  wire logic        DUAL3V3_SLEEP_ENABLE,
	input  wire logic        DUAL5V_SLEEP_ENABLE,
	// Supply, soft-start and temperature comparators.
	input  wire logic        STANDBY_SUPPLY_OK,
	input  wire logic        MAIN12V_OK,
	input  wire logic        SOFT_START_LOW,
	input  wire logic        SOFT_START_DONE,
	input  wire logic        OVER_TEMP_WARN,
	input  wire logic        OVER_TEMP_SHUTDOWN,
	// Rail under-voltage comparators.
	input  wire logic        MEM_RAIL_SENSE_UV,
	input  wire logic        DUAL3V3_RAIL_SENSE_UV,
	input  wire logic        DUAL5V_RAIL_SENSE_UV,
	// Shared fault and memory select pin.
	input  wire logic        FAULT_MEMSEL_PIN_I,
	output logic             FAULT_MEMSEL_PIN_O,
	output logic             FAULT_MEMSEL_PIN_OE_N,
	// Rail drives.
	output logic             ACTIVE_SWITCH_DRIVE,
	output logic             DUAL3V3_STANDBY_DRIVE,
	output logic             DUAL5V_STANDBY_DRIVE,
	output logic             MEM_ACTIVE_DRIVE,
	output logic             MEM_FULL_ON,
	output logic             MEM_SLEEP_PASS,
	output logic             SOFT_START_RUN
);
	import sleep_seq_pkg::*;

	// ======================================================================
	// Input synchronisers
	// ======================================================================
	logic [`PIN_COUNT-1:0] pin_raw;
	logic [`PIN_COUNT-1:0] pin_meta_reg;
	logic [`PIN_COUNT-1:0] pin_reg;

	// Gather every asynchronous input into one vector.
	assign pin_raw[`PIN_S3N]       = SUSPEND_RAM_REQ_N;
	assign pin_raw[`PIN_S5N]       = SOFT_OFF_REQ_N;
	assign pin_raw[`PIN_EN3]       = DUAL3V3_SLEEP_ENABLE;
	assign pin_raw[`PIN_EN5]       = DUAL5V_SLEEP_ENABLE;
	assign pin_raw[`PIN_STBY_OK]   = STANDBY_SUPPLY_OK;
	assign pin_raw[`PIN_12V_OK]    = MAIN12V_OK;
	assign pin_raw[`PIN_SS_LOW]    = SOFT_START_LOW;
	assign pin_raw[`PIN_SS_DONE]   = SOFT_START_DONE;
	assign pin_raw[`PIN_MEM_UV]    = MEM_RAIL_SENSE_UV;
	assign pin_raw[`PIN_D3_UV]     = DUAL3V3_RAIL_SENSE_UV;
	assign pin_raw[`PIN_D5_UV]     = DUAL5V_RAIL_SENSE_UV;
	assign pin_raw[`PIN_OT_WARN]   = OVER_TEMP_WARN;
	assign pin_raw[`PIN_OT_SHUT]   = OVER_TEMP_SHUTDOWN;
	assign pin_raw[`PIN_FAULT_IN]  = FAULT_MEMSEL_PIN_I;

	// Two flops per pin, request pins reset idle high; logic reads stage two.
	genvar gi;
	generate
		for (gi = 0; gi < `PIN_COUNT; gi++)
		begin : g_sync
			always_ff @(posedge CLK or negedge NRST)
			begin
				if (!NRST)
				begin
					pin_meta_reg[gi] <= (gi == `PIN_S3N) || (gi == `PIN_S5N);
					pin_reg[gi]      <= (gi == `PIN_S3N) || (gi == `PIN_S5N);
				end
				else
				begin
					pin_meta_reg[gi] <= pin_raw[gi];
					pin_reg[gi]      <= pin_meta_reg[gi];
				end
			end
		end
	endgenerate

	// ======================================================================
	// Request decode
	// ======================================================================
	wire        s3n        = pin_reg[`PIN_S3N];
	wire        s5n        = pin_reg[`PIN_S5N];
	wire        stby_ok    = pin_reg[`PIN_STBY_OK];
	wire        ss_done    = pin_reg[`PIN_SS_DONE];
	wire [1:0]  req_now    = {s5n, s3n};
	wire        req_active = s5n & s3n;
	wire        req_susp   = s5n & ~s3n;
	wire        req_off    = ~s5n & ~s3n;
	wire        req_valid  = ~(~s5n & s3n);
	wire        req_sleep  = req_susp | req_off;
	wire seq_state_e sleep_target = req_susp ? ST_SUSPEND : ST_SOFTOFF;

	// ======================================================================
	// State and counters
	// ======================================================================
	seq_state_e            state_reg;
	seq_state_e            state_next;
	seq_state_e            pend_reg;
	seq_state_e            pend_next;
	logic [`CNT_W-1:0]     por_cnt_reg;
	logic                  por_done_reg;
	logic [`CNT_W-1:0]     msel_cnt_reg;
	logic                  msel_done_reg;
	logic                  memsel33_reg;
	logic [`CNT_W-1:0]     deg_cnt_reg;
	logic                  deg_busy_reg;
	logic [1:0]            req_prev_reg;
	logic [`CNT_W-1:0]     w12_cnt_reg;
	logic                  en3_reg;
	logic                  en5_reg;
	logic [31:0]           ctrl_reg;
	drive_s                drive_reg;
	drive_s                drive_next;

	wire sw_shutdown = ctrl_reg[`CTRL_SHUTDOWN_BIT];
	wire shut_req    = pin_reg[`PIN_SS_LOW] | sw_shutdown;
	wire is_sleep    = (state_reg == ST_SUSPEND) | (state_reg == ST_SOFTOFF);
	wire deg_fire    = deg_busy_reg & (deg_cnt_reg == `CNT_W'(1));
	wire ramping     = (state_reg == ST_ACTIVE) & ~ss_done;
	wire por_end     = por_cnt_reg == `CNT_W'(POR_EXT_CYC - 1);
	wire w12_end     = w12_cnt_reg == `CNT_W'(MAIN12V_WAIT_CYC - 1);
	wire msel_end    = msel_cnt_reg == `CNT_W'(MSEL_LATCH_CYC - 1);
	wire req_change  = req_now != req_prev_reg;

	// Power-on reset extension counter; restarts whenever supply drops.
	// reset extension
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			por_cnt_reg  <= '0;
			por_done_reg <= 1'b0;
		end
		else if (!stby_ok)
		begin
			por_cnt_reg  <= '0;
			por_done_reg <= 1'b0;
		end
		else if (!por_done_reg)
		begin
			por_cnt_reg  <= por_cnt_reg + `CNT_W'(1);
			por_done_reg <= por_end;
		end
	end

	// Memory voltage selection is sampled once, a fixed time after release.
	// selection latch
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			msel_cnt_reg  <= '0;
			msel_done_reg <= 1'b0;
			memsel33_reg  <= 1'b0;
		end
		else if (!por_done_reg)
		begin
			msel_cnt_reg  <= '0;
			msel_done_reg <= 1'b0;
		end
		else if (!msel_done_reg)
		begin
			msel_cnt_reg  <= msel_cnt_reg + `CNT_W'(1);
			msel_done_reg <= msel_end;
			memsel33_reg  <= msel_end ? pin_reg[`PIN_FAULT_IN] : memsel33_reg;
		end
	end

	// Any request pin change restarts the deglitch timer; it also covers
	// the skew between the two requests on entry to soft-off.
	// deglitch timer
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			req_prev_reg <= 2'b11;
			deg_cnt_reg  <= '0;
			deg_busy_reg <= 1'b0;
		end
		else
		begin
			req_prev_reg <= req_now;
			if (req_change)
			begin
				deg_cnt_reg  <= `CNT_W'(DEGLITCH_CYC);
				deg_busy_reg <= 1'b1;
			end
			else if (deg_busy_reg)
			begin
				deg_cnt_reg  <= deg_cnt_reg - `CNT_W'(1);
				deg_busy_reg <= ~deg_fire;
			end
		end
	end

	// Main 12V settle timer, running only while waiting to go active.
	// 12V timeout
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
			w12_cnt_reg <= '0;
		else if (state_reg != ST_WAIT12 || !pin_reg[`PIN_12V_OK])
			w12_cnt_reg <= '0;
		else if (!w12_end)
			w12_cnt_reg <= w12_cnt_reg + `CNT_W'(1);
	end

	// ======================================================================
	// Sequencer
	// ======================================================================
	// Next state; sleep-to-sleep moves and invalid requests are ignored.
	always_comb
	begin
		state_next = state_reg;
		pend_next  = pend_reg;
		if (!stby_ok)
			state_next = ST_POR;
		else if (pin_reg[`PIN_OT_SHUT] || state_reg == ST_THERMAL)
			state_next = ST_THERMAL;
		else if (shut_req && state_reg != ST_POR)
			state_next = ST_SHUTDOWN;
		else
		begin
			case (state_reg)
				ST_POR:
					if (por_done_reg && req_valid)
						state_next = req_active ? ST_WAIT12 : sleep_target;
				ST_SHUTDOWN:
					if (req_valid)
						state_next = req_active ? ST_WAIT12 : sleep_target;
				ST_WAIT12:
					if (deg_fire && req_sleep)
						state_next = sleep_target;
					else if (w12_end)
						state_next = ST_ACTIVE;
				ST_ACTIVE:
					if (deg_fire && req_sleep)
					begin
						state_next = ramping ? ST_RESTART : sleep_target;
						pend_next  = sleep_target;
					end
				ST_RESTART:
					state_next = pend_reg;
				ST_SUSPEND, ST_SOFTOFF:
					if (deg_fire && req_active)
						state_next = ST_WAIT12;
				default:
					state_next = ST_POR;
			endcase
		end
	end

	// Enables are captured only at the defined moments.
	// enable capture
	wire next_sleep = (state_next == ST_SUSPEND) | (state_next == ST_SOFTOFF);
	wire en_latch   = (next_sleep & ~is_sleep)
	                | ((state_reg == ST_POR) & (state_next != ST_POR))
	                | ((state_reg == ST_SHUTDOWN) & (state_next != ST_SHUTDOWN));

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			state_reg <= ST_POR;
			pend_reg  <= ST_SOFTOFF;
			en3_reg   <= 1'b0;
			en5_reg   <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			pend_reg  <= pend_next;
			en3_reg   <= en_latch ? pin_reg[`PIN_EN3] : en3_reg;
			en5_reg   <= en_latch ? pin_reg[`PIN_EN5] : en5_reg;
		end
	end

	// ======================================================================
	// Rail drives
	// ======================================================================
	// Drives follow the state; nothing ramps before the selection is held.
	always_comb
	begin
		drive_next = '0;
		if (msel_done_reg)
		begin
			case (state_reg)
				ST_ACTIVE:
				begin
					drive_next.active_switch_drive = 1'b1;
					drive_next.mem_active_drive    = 1'b1;
					drive_next.mem_full_on         = memsel33_reg;
					drive_next.soft_start_run      = 1'b1;
				end
				ST_SUSPEND:
				begin
					drive_next.dual3v3_standby_drive = 1'b1;
					drive_next.dual5v_standby_drive  = en5_reg;
					drive_next.mem_sleep_pass        = 1'b1;
					drive_next.soft_start_run        = 1'b1;
				end
				ST_SOFTOFF:
				begin
					drive_next.dual3v3_standby_drive = ~en3_reg;
					drive_next.dual5v_standby_drive  = en5_reg;
					drive_next.soft_start_run        = 1'b1;
				end
				default:
					drive_next = '0;
			endcase
		end
	end

	// ======================================================================
	// Fault reporting
	// ======================================================================
	// Monitors arm once soft-start has finished; only enabled rails count.
	// under-voltage monitor
	wire uv_armed = drive_reg.soft_start_run & ss_done;
	wire d3_on    = drive_reg.active_switch_drive
	              | drive_reg.dual3v3_standby_drive;
	wire d5_on    = drive_reg.active_switch_drive
	              | drive_reg.dual5v_standby_drive;
	wire mem_on   = drive_reg.mem_active_drive | drive_reg.mem_sleep_pass;
	wire uv_any   = uv_armed & ((pin_reg[`PIN_MEM_UV] & mem_on)
	              | (pin_reg[`PIN_D3_UV] & d3_on)
	              | (pin_reg[`PIN_D5_UV] & d5_on));
	wire fault_next = ~shut_req & (uv_any | pin_reg[`PIN_OT_WARN]);
	// Pin is driven while a fault shows or while shutdown forces it low.
	wire drive_pin  = fault_next | (state_next == ST_SHUTDOWN);

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			drive_reg             <= '0;
			FAULT_MEMSEL_PIN_O    <= 1'b0;
			FAULT_MEMSEL_PIN_OE_N <= 1'b1;
		end
		else
		begin
			drive_reg             <= shut_req ? '0 : drive_next;
			FAULT_MEMSEL_PIN_O    <= fault_next;
			FAULT_MEMSEL_PIN_OE_N <= ~drive_pin;
		end
	end

	assign ACTIVE_SWITCH_DRIVE   = drive_reg.active_switch_drive;
	assign DUAL3V3_STANDBY_DRIVE = drive_reg.dual3v3_standby_drive;
	assign DUAL5V_STANDBY_DRIVE  = drive_reg.dual5v_standby_drive;
	assign MEM_ACTIVE_DRIVE      = drive_reg.mem_active_drive;
	assign MEM_FULL_ON           = drive_reg.mem_full_on;
	assign MEM_SLEEP_PASS        = drive_reg.mem_sleep_pass;
	assign SOFT_START_RUN        = drive_reg.soft_start_run;

	// ======================================================================
	// AHB-Lite register slave
	// ======================================================================
	// Address phase decode; read data is prepared for the data phase.
	wire        ahb_take   = HSEL & HTRANS[1] & HREADY;
	wire        hit_ctrl   = HADDR[7:0] == `CTRL_OFFSET;
	wire        hit_status = HADDR[7:0] == `STATUS_OFFSET;
	wire        in_page    = HADDR[31:8] == 24'h00_0000;
	logic [31:0] status_word;
	logic [31:0] rdata_next;
	logic        wr_pend_reg;

	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[`ST_STATE_LSB +: 3] = state_reg;
		status_word[`ST_EN3_BIT]       = en3_reg;
		status_word[`ST_EN5_BIT]       = en5_reg;
		status_word[`ST_MEMSEL_BIT]    = memsel33_reg;
		status_word[`ST_FAULT_BIT]     = FAULT_MEMSEL_PIN_O;
		status_word[`ST_PORDONE_BIT]   = por_done_reg;
		status_word[`ST_UVARM_BIT]     = uv_armed;
		status_word[`ST_MSELDONE_BIT]  = msel_done_reg;
		rdata_next = 32'h0000_0000;
		if (ahb_take && !HWRITE && in_page && hit_ctrl)
			rdata_next = ctrl_reg;
		else if (ahb_take && !HWRITE && in_page && hit_status)
			rdata_next = status_word;
	end

	// Writes land in the data phase; status is read-only.
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			wr_pend_reg <= 1'b0;
			ctrl_reg    <= `CTRL_RESET;
			HRDATA      <= 32'h0000_0000;
			HREADYOUT   <= 1'b1;
			HRESP       <= 1'b0;
		end
		else
		begin
			wr_pend_reg <= ahb_take & HWRITE & in_page & hit_ctrl;
			ctrl_reg    <= wr_pend_reg ? {31'h0000_0000,
			               HWDATA[`CTRL_SHUTDOWN_BIT]} : ctrl_reg;
			HRDATA      <= rdata_next;
			HREADYOUT   <= 1'b1;
			HRESP       <= 1'b0;
		end
	end

endmodule

// [rtl/sleep_seq_defines.svh]
// Purpose: Offsets, field positions and timing counts of the rail sequencer.
// Assumes: 100 MHz system clock.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
`ifndef SLEEP_SEQ_DEFINES_SVH
`define SLEEP_SEQ_DEFINES_SVH

// ==========================================================================
// Clock and timing
// ==========================================================================
`define CLK_PERIOD_NS    10
`define POR_EXT_US       3300
`define MSEL_LATCH_US    3000
`define DEGLITCH_US      200
`define MAIN12V_WAIT_US  50000
`define POR_EXT_CYC      ((`POR_EXT_US * 1000) / `CLK_PERIOD_NS)
`define MSEL_LATCH_CYC   ((`MSEL_LATCH_US * 1000) / `CLK_PERIOD_NS)
`define DEGLITCH_CYC     ((`DEGLITCH_US * 1000) / `CLK_PERIOD_NS)
`define MAIN12V_WAIT_CYC ((`MAIN12V_WAIT_US * 1000) / `CLK_PERIOD_NS)
`define CNT_W            23

// ==========================================================================
// Register map
// ==========================================================================
`define CTRL_OFFSET      8'h00
`define STATUS_OFFSET    8'h04
`define CTRL_RESET       32'h0000_0000
`define CTRL_SHUTDOWN_BIT 0
`define ST_STATE_LSB     0
`define ST_EN3_BIT       3
`define ST_EN5_BIT       4
`define ST_MEMSEL_BIT    5
`define ST_FAULT_BIT     6
`define ST_PORDONE_BIT   7
`define ST_UVARM_BIT     8
`define ST_MSELDONE_BIT  9

// ==========================================================================
// Synchronised pin positions
// ==========================================================================
`define PIN_COUNT        14
`define PIN_S3N          0
`define PIN_S5N          1
`define PIN_EN3          2
`define PIN_EN5          3
`define PIN_STBY_OK      4
`define PIN_12V_OK       5
`define PIN_SS_LOW       6
`define PIN_SS_DONE      7
`define PIN_MEM_UV       8
`define PIN_D3_UV        9
`define PIN_D5_UV        10
`define PIN_OT_WARN      11
`define PIN_OT_SHUT      12
`define PIN_FAULT_IN     13

`endif

// [rtl/sleep_seq_pkg.sv]
// Purpose: Types shared by the rail sequencer.
// Assumes: Nothing beyond the defines header.
// Notes:   Output drives travel together as one packed struct.
package sleep_seq_pkg;

	// ======================================================================
	// Sequencer states
	// ======================================================================
	typedef enum logic [2:0]
	{
		ST_POR      = 3'b000,
		ST_WAIT12   = 3'b001,
		ST_ACTIVE   = 3'b010,
		ST_SUSPEND  = 3'b011,
		ST_SOFTOFF  = 3'b100,
		ST_RESTART  = 3'b101,
		ST_SHUTDOWN = 3'b110,
		ST_THERMAL  = 3'b111
	} seq_state_e;

	// ======================================================================
	// Rail drive bundle
	// ======================================================================
	typedef struct packed
	{
		logic active_switch_drive;
		logic dual3v3_standby_drive;
		logic dual5v_standby_drive;
		logic mem_active_drive;
		logic mem_full_on;
		logic mem_sleep_pass;
		logic soft_start_run;
	} drive_s;

endpackage

// [testbench/sleep_seq_properties.sv]
// Purpose: Port-level checks of the rail sequencer.
// Assumes: Drives and fault pin follow the synced inputs.
// Notes:   Bound to the top module at the foot of this file.
`timescale 1ns/1ps
module sleep_seq_properties
#(
	parameter int DEGLITCH_CYC = 8
)
(
	// Clock, reset and bus.
	input wire logic        CLK,
	input wire logic        NRST,
	input wire logic        HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic        HREADY,
	input wire logic        HREADYOUT,
	input wire logic        HRESP,
	input wire logic [31:0] HRDATA,
	// Requests and fault causes.
	input wire logic        SUSPEND_RAM_REQ_N,
	input wire logic        SOFT_OFF_REQ_N,
	input wire logic        SOFT_START_LOW,
	input wire logic        OVER_TEMP_WARN,
	// Fault pin and drives.
	input wire logic        FAULT_MEMSEL_PIN_O,
	input wire logic        FAULT_MEMSEL_PIN_OE_N,
	input wire logic        ACTIVE_SWITCH_DRIVE,
	input wire logic        DUAL3V3_STANDBY_DRIVE,
	input wire logic        DUAL5V_STANDBY_DRIVE,
	input wire logic        MEM_ACTIVE_DRIVE,
	input wire logic        MEM_SLEEP_PASS
);
	logic [7:0] quiet_reg;
	logic [1:0] req_reg;
	// ====================
	// Counts cycles since either request pin last moved.
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			quiet_reg <= 8'hFF;
			req_reg <= 2'b11;
		end
		else
		begin
			req_reg <= {SUSPEND_RAM_REQ_N, SOFT_OFF_REQ_N};
			if (req_reg != {SUSPEND_RAM_REQ_N, SOFT_OFF_REQ_N})
				quiet_reg <= 8'h00;
			else if (quiet_reg != 8'hFF)
				quiet_reg <= quiet_reg + 8'h01;
		end
	end
	// ====================
	// Properties on one clock, all held off in reset.
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	sequence s_shut;
		SOFT_START_LOW [*6];
	endsequence
	sequence s_hot;
		(OVER_TEMP_WARN && ACTIVE_SWITCH_DRIVE && !SOFT_START_LOW) [*5];
	endsequence
	sequence s_rd_unmapped;
		HSEL && HTRANS[1] && HREADY && !HWRITE && HADDR != 32'h0
			&& HADDR != 32'h4;
	endsequence
	a_bus_okay: assert property (HREADYOUT && !HRESP)
		else $error("bus answered with wait or error");
	a_switch_excl: assert property (
		ACTIVE_SWITCH_DRIVE |-> !DUAL3V3_STANDBY_DRIVE
			&& !DUAL5V_STANDBY_DRIVE && !MEM_SLEEP_PASS)
		else $error("sleep drive on beside active switch");
	a_memdrv_active: assert property (
		MEM_ACTIVE_DRIVE |-> ACTIVE_SWITCH_DRIVE)
		else $error("memory drive on outside active state");
	a_pass_dual3: assert property (
		MEM_SLEEP_PASS |-> DUAL3V3_STANDBY_DRIVE)
		else $error("suspend without the 3.3V dual rail");
	a_shut_off: assert property (
		s_shut |-> !ACTIVE_SWITCH_DRIVE && !DUAL3V3_STANDBY_DRIVE
			&& !DUAL5V_STANDBY_DRIVE && !MEM_ACTIVE_DRIVE
			&& !MEM_SLEEP_PASS && !FAULT_MEMSEL_PIN_O
			&& !FAULT_MEMSEL_PIN_OE_N)
		else $error("shutdown left a drive or fault on");
	a_temp_fault: assert property (
		s_hot |-> FAULT_MEMSEL_PIN_O && !FAULT_MEMSEL_PIN_OE_N)
		else $error("heat warning not reported");
	a_unmapped_zero: assert property (
		s_rd_unmapped |=> HRDATA == 32'h0)
		else $error("unmapped read gave data");
	a_deglitch_quiet: assert property (
		$rose(ACTIVE_SWITCH_DRIVE) || $rose(DUAL3V3_STANDBY_DRIVE)
			|-> quiet_reg >= DEGLITCH_CYC)
		else $error("state taken before requests settled");
endmodule
bind acpi_sleep_rail_sequencer sleep_seq_properties
	#(.DEGLITCH_CYC(DEGLITCH_CYC)) props_inst (.*);

// [testbench/chipset_model.sv]
// Purpose: Chipset side driving sleep requests and enable pins.
// Assumes: Bench commands change right after a rising clock edge.
// Notes:   Mode 3 shows the forbidden pair only when the bench asks.
`timescale 1ns/1ps
module chipset_model
#(
	parameter int SKEW = 5
)
(
	// Clock and bench commands.
	input  wire logic       clk,
	input  wire logic [1:0] mode,
	input  wire logic       glitch,
	input  wire logic [1:0] en_want,
	// Pins toward the sequencer.
	output logic            s3_n,
	output logic            s5_n,
	output logic            en3,
	output logic            en5
);
	logic [3:0] skew_reg = 4'h0;
	logic       s3_reg = 1'b0;
	logic       s5_reg = 1'b1;
	logic [1:0] en_reg = 2'b11;
	// Pins follow the registered values.
	assign {s3_n, s5_n} = {s3_reg, s5_reg};
	assign {en5, en3} = en_reg;
	// Mode 0 active, 1 suspend, 2 soft-off, 3 forbidden pair.
	// Suspend leads soft-off; enables move on command.
	always @(posedge clk)
	begin
		en_reg <= en_want;
		if (mode != 2'd2)
			skew_reg <= 4'h0;
		else if (skew_reg != 4'(SKEW))
			skew_reg <= skew_reg + 4'h1;
		s3_reg <= glitch ? ~s3_reg : (mode == 2'd0 || mode == 2'd3);
		s5_reg <= !(mode == 2'd3 || (mode == 2'd2 && skew_reg == 4'(SKEW)));
	end
endmodule

// [testbench/tb_acpi_sleep_rail_sequencer.sv]
// Purpose: Self-checking bench for the rail sequencer.
// Assumes: Shortened counts; enables drawn from an LFSR.
// Notes:   Sleep pins and enables come from the chipset model.
`timescale 1ns/1ps
module tb_acpi_sleep_rail_sequencer;
	localparam int POR = 20, MSL = 10, W12 = 16;
	// ====================
	// Stimulus and observed signals.
	logic        CLK = 1'b0, NRST = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
	logic [1:0]  HTRANS = 2'b00, mode = 2'd1, en_want = 2'b11;
	logic [2:0]  HSIZE = 3'b010;
	logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, lfsr = 32'h5A69;
	logic        STANDBY_SUPPLY_OK = 1'b1, MAIN12V_OK = 1'b0;
	logic        SOFT_START_LOW = 1'b0, SOFT_START_DONE = 1'b1;
	logic        OVER_TEMP_SHUTDOWN = 1'b0, strap = 1'b0, glitch = 1'b0;
	logic [3:0]  flt = 4'h0;
	int          n_errors = 0, num_checks = 0;
	wire         HREADY, HREADYOUT, HRESP, FAULT_MEMSEL_PIN_I;
	wire [31:0]  HRDATA;
	wire         SUSPEND_RAM_REQ_N, SOFT_OFF_REQ_N, SOFT_START_RUN;
	wire         DUAL3V3_SLEEP_ENABLE, DUAL5V_SLEEP_ENABLE, MEM_FULL_ON;
	wire         FAULT_MEMSEL_PIN_O, FAULT_MEMSEL_PIN_OE_N, MEM_SLEEP_PASS;
	wire         ACTIVE_SWITCH_DRIVE, DUAL3V3_STANDBY_DRIVE;
	wire         DUAL5V_STANDBY_DRIVE, MEM_ACTIVE_DRIVE;
	wire         OVER_TEMP_WARN = flt[3], DUAL5V_RAIL_SENSE_UV = flt[2];
	wire         DUAL3V3_RAIL_SENSE_UV = flt[1], MEM_RAIL_SENSE_UV = flt[0];
	wire [3:0]   drv = {ACTIVE_SWITCH_DRIVE, DUAL3V3_STANDBY_DRIVE,
		DUAL5V_STANDBY_DRIVE, MEM_SLEEP_PASS};
	// One slave on the bus; the shared pin shows the strap when released.
	assign HREADY = HREADYOUT;
	assign FAULT_MEMSEL_PIN_I = FAULT_MEMSEL_PIN_OE_N ? strap
		: FAULT_MEMSEL_PIN_O;
	acpi_sleep_rail_sequencer #(.POR_EXT_CYC(POR), .MSEL_LATCH_CYC(MSL),
		.DEGLITCH_CYC(8), .MAIN12V_WAIT_CYC(W12))
		acpi_sleep_rail_sequencer_inst (.*);
	chipset_model chipset_model_inst (.clk(CLK), .mode(mode),
		.glitch(glitch), .en_want(en_want), .s3_n(SUSPEND_RAM_REQ_N),
		.s5_n(SOFT_OFF_REQ_N), .en3(DUAL3V3_SLEEP_ENABLE),
		.en5(DUAL5V_SLEEP_ENABLE));
	// ====================
	// Helpers.
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Expected {switch, standby 3.3V, standby 5V, pass} for a state.
	function automatic logic [3:0] xd(input logic [1:0] s, input logic [1:0] e);
		if (s == 2'd0)
			return 4'b1000;
		if (s == 2'd1)
			return {2'b01, e[1], 1'b1};
		return {1'b0, ~e[0], e[1], 1'b0};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("errors %0d checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Waits a bounded time for the drives to reach a pattern.
	task automatic settle(input logic [3:0] e, output int n);
		n = 0;
		while (drv !== e && n < 300)
		begin
			@(posedge CLK);
			n++;
		end
		chk(drv, e);
	endtask
	// One AHB-Lite single word transfer.
	task automatic bus(input logic w, input logic [31:0] a, d,
		output logic [31:0] r);
		@(posedge CLK);
		HSEL <= 1'b1;
		HADDR <= a;
		HWRITE <= w;
		HTRANS <= 2'b10;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'b00;
		HWDATA <= d;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		r = HRDATA;
	endtask
	// Clock and watchdog.
	initial
		forever #5 CLK = ~CLK;
	initial
	begin
		repeat (20000) @(posedge CLK);
		n_errors++;
		finish_test;
	end
	// Main sequence.
	initial
	begin
		int n;
		logic [31:0] r;
		logic [1:0] s;
		repeat (4) @(posedge CLK);
		NRST <= 1'b1;
		settle(xd(2'd1, 2'b11), n);
		chk(n >= POR + MSL, 1'b1);
		strap <= 1'b1;
		bus(1'b0, 32'h4, 32'h0, r);
		chk({r[9], r[5:0]}, 7'h5B);
		// Enable moves, a glitch and blocked requests leave suspend alone.
		en_want <= 2'b00;
		glitch <= 1'b1;
		repeat (3) @(posedge CLK);
		glitch <= 1'b0;
		repeat (40) @(posedge CLK);
		chk(drv, xd(2'd1, 2'b11));
		for (int m = 2; m < 4; m++)
		begin
			mode <= m[1:0];
			repeat (60) @(posedge CLK);
			chk(drv, xd(2'd1, 2'b11));
		end
		MAIN12V_OK <= 1'b1;
		mode <= 2'd0;
		settle(4'b1000, n);
		chk(n >= W12, 1'b1);
		chk({MEM_ACTIVE_DRIVE, MEM_FULL_ON, SOFT_START_RUN}, 3'b101);
		// Random enables, each followed by a sleep state and wake-up.
		for (int i = 0; i < 6; i++)
		begin
			lfsr = nxt(lfsr);
			s = {lfsr[2], ~lfsr[2]};
			en_want <= lfsr[1:0];
			repeat (6) @(posedge CLK);
			mode <= s;
			settle(xd(s, lfsr[1:0]), n);
			mode <= 2'd0;
			settle(4'b1000, n);
		end
		// Each fault cause raises the shared pin, then frees it.
		for (int i = 0; i < 4; i++)
		begin
			flt <= 4'h1 << i;
			repeat (6) @(posedge CLK);
			chk({FAULT_MEMSEL_PIN_I, FAULT_MEMSEL_PIN_OE_N}, 2'b10);
			flt <= 4'h0;
			repeat (6) @(posedge CLK);
			chk(FAULT_MEMSEL_PIN_OE_N, 1'b1);
		end
		// Shutdown by pin with a fault pending, then by register.
		flt <= 4'h2;
		SOFT_START_LOW <= 1'b1;
		repeat (8) @(posedge CLK);
		chk({drv, MEM_ACTIVE_DRIVE, FAULT_MEMSEL_PIN_I}, 6'h0);
		SOFT_START_LOW <= 1'b0;
		flt <= 4'h0;
		bus(1'b1, 32'h0, 32'h1, r);
		repeat (8) @(posedge CLK);
		chk(drv, 4'h0);
		bus(1'b0, 32'h0, 32'h0, r);
		chk(r, 32'h1);
		bus(1'b0, 32'h8, 32'h0, r);
		chk(r, 32'h0);
		bus(1'b1, 32'h0, 32'h0, r);
		settle(4'b1000, n);
		// A sleep request during the active ramp restarts into sleep.
		SOFT_START_DONE <= 1'b0;
		mode <= 2'd1;
		settle(4'h0, n);
		settle(xd(2'd1, en_want), n);
		// Supply loss restarts the sequence; the strap now selects 3.3V.
		STANDBY_SUPPLY_OK <= 1'b0;
		settle(4'h0, n);
		STANDBY_SUPPLY_OK <= 1'b1;
		settle(xd(2'd1, en_want), n);
		bus(1'b0, 32'h4, 32'h0, r);
		chk(r[5], 1'b1);
		finish_test;
	end
endmodule
